// ==== hdl/rfg_defs.svh ====
// constants for the reset, flash guard and clock select block
// assumes an 8-bit special-function-register bus and a 25 MHz clock
`ifndef RFG_DEFS_SVH
`define RFG_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
`define RFG_ADDR_CLKSRC 8'ha9
`define RFG_ADDR_RESET_SOURCE_REGISTER 8'hef
`define RFG_ADDR_PROGRAM_STORE_CONTROL 8'h8f

////////////////////////////////////////////////////////////////////////////////
`define RFG_CLKSRC_SEL_BIT 0
`define RFG_RESET_SOURCE_REGISTER_PIN_BIT 0
`define RFG_RESET_SOURCE_REGISTER_SMON_BIT 1
`define RFG_PROGRAM_STORE_CONTROL_WE_BIT 0
`define RFG_PROGRAM_STORE_CONTROL_EE_BIT 1

////////////////////////////////////////////////////////////////////////////////
`define RFG_CLKSRC_RESET 8'h00
`define RFG_CLKSRC_SEL_RESET 1'b0
`define RFG_RESET_SOURCE_REGISTER_RESET 8'h00
`define RFG_PROGRAM_STORE_CONTROL_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
`define RFG_CLK_NS 40
`define RFG_GAP_NS 80
`define RFG_GAP_CYC ((`RFG_GAP_NS + `RFG_CLK_NS - 1) / `RFG_CLK_NS)

`endif

// ==== hdl/rfg_pkg.sv ====
// types shared by the reset, flash guard and clock select block
// assumes nothing beyond the constants header
package rfg_pkg;

    typedef enum logic [1:0] {
        RFG_SW_INT = 2'b00,
        RFG_SW_OFF = 2'b01,
        RFG_SW_EXT = 2'b10
    } rfg_sw_state_t;

    typedef logic [7:0] rfg_byte_t;

endpackage : rfg_pkg

// ==== hdl/rfg_clk_switch.sv ====
// break-before-make control of the system clock source gates on a select change; sys_rst goes straight to internal with no gap
// assumes the gates are sampled by a glitch-free cell on the clock edge
`timescale 1ns/10ps
`include "rfg_defs.svh"

module rfg_clk_switch
    import rfg_pkg::*;
#(
    parameter int GAP_CYC = `RFG_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic sys_rst,
    // request
    input wire logic sel_ext,
    // gates
    output logic int_en,
    output logic ext_en
);

    rfg_sw_state_t state_q, state_d;
    logic [7:0] gap_q, gap_d;
    logic int_en_d, ext_en_d;

    ////////////////////////////////////////////////////////////////////////////
    // both gates off for a gap
    always_comb begin
        state_d = state_q;
        gap_d = gap_q;
        case (state_q)
            RFG_SW_INT: begin
                if (sel_ext) begin
                    state_d = RFG_SW_OFF;
                    gap_d = 8'h00;
                end
            end
            RFG_SW_EXT: begin
                if (!sel_ext) begin
                    state_d = RFG_SW_OFF;
                    gap_d = 8'h00;
                end
            end
            RFG_SW_OFF: begin
                // new source only after the old one is fully stopped
                if (gap_q >= 8'(GAP_CYC - 1)) begin
                    state_d = sel_ext ? RFG_SW_EXT : RFG_SW_INT;
                end else begin
                    gap_d = gap_q + 8'h01;
                end
            end
            default: begin
                state_d = RFG_SW_INT;
            end
        endcase
        if (sys_rst) begin
            state_d = RFG_SW_INT;
            gap_d = 8'h00;
        end
        int_en_d = (state_d == RFG_SW_INT);
        ext_en_d = (state_d == RFG_SW_EXT);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= RFG_SW_INT;
            gap_q <= 8'h00;
            int_en <= 1'b1;
            ext_en <= 1'b0;
        end else begin
            state_q <= state_d;
            gap_q <= gap_d;
            int_en <= int_en_d;
            ext_en <= ext_en_d;
        end
    end

endmodule : rfg_clk_switch

// ==== hdl/rfg_top.sv ====
// reset pin handling, reset-source flags, flash write guard, interrupt
// deferral and system clock source selection
// assumes a synchronous sfr bus and a reset pin already in the clk domain
`timescale 1ns/10ps
`include "rfg_defs.svh"

module rfg_top
    import rfg_pkg::*;
#(
    parameter int IRQ_N = 8,
    parameter int DIV_W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // external reset pin
    input wire logic rst_pin_n,
    // sfr bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_q,
    // system reset
    output logic sys_reset_q,
    // supply monitor
    output logic supply_monitor_reset_select_q,
    // flash guard
    input wire logic flash_busy,
    output logic flash_write_permit_q,
    output logic flash_erase_permit_q,
    // interrupts
    input wire logic int_global_en,
    input wire logic [IRQ_N-1:0] irq_req,
    input wire logic [IRQ_N-1:0] irq_ack,
    output logic [IRQ_N-1:0] irq_pending_q,
    output logic [IRQ_N-1:0] irq_service_q,
    // clock source
    input wire logic [DIV_W-1:0] internal_divider_field,
    output logic [DIV_W-1:0] system_clock_div_q,
    output logic int_osc_gate_q,
    output logic ext_osc_gate_q
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic clock_source_bit_q, clock_source_bit_d;
    logic smon_sel_d;
    logic pin_reset_flag_q, pin_reset_flag_d;
    logic prog_we_q, prog_we_d;
    logic prog_ee_q, prog_ee_d;
    logic sys_reset_d;
    logic pin_low_q, pin_low_d;
    logic [7:0] rdata_d;
    logic [IRQ_N-1:0] pend_d, serv_d;
    logic [DIV_W-1:0] div_d;
    logic wr_ok;

    function automatic logic [IRQ_N-1:0] rfg_first(input logic [IRQ_N-1:0] v);
        logic [IRQ_N-1:0] r;
        r = '0;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : rfg_first

    ////////////////////////////////////////////////////////////////////////////
    // reset group
    always_comb begin
        sys_reset_d = !rst_pin_n;
        pin_low_d = !rst_pin_n;
        pin_reset_flag_d = pin_reset_flag_q;
        // set on leaving pin reset
        // tracks the pin itself so power-on reset leaves the flag clear
        if (pin_low_q && rst_pin_n) begin
            pin_reset_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_reset_q <= 1'b1;
            pin_low_q <= 1'b0;
            pin_reset_flag_q <= 1'b0;
        end else begin
            sys_reset_q <= sys_reset_d;
            pin_low_q <= pin_low_d;
            pin_reset_flag_q <= pin_reset_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register group
    always_comb begin
        wr_ok = sfr_wr && rst_pin_n;
        clock_source_bit_d = clock_source_bit_q;
        smon_sel_d = supply_monitor_reset_select_q;
        prog_we_d = prog_we_q;
        prog_ee_d = prog_ee_q;
        if (wr_ok) begin
            case (sfr_addr)
                `RFG_ADDR_CLKSRC: begin
                    clock_source_bit_d = sfr_wdata[`RFG_CLKSRC_SEL_BIT];
                end
                `RFG_ADDR_RESET_SOURCE_REGISTER: begin
                    // only the smon bit is written, pin flag read only
                    smon_sel_d = sfr_wdata[`RFG_RESET_SOURCE_REGISTER_SMON_BIT];
                end
                `RFG_ADDR_PROGRAM_STORE_CONTROL: begin
                    prog_we_d = sfr_wdata[`RFG_PROGRAM_STORE_CONTROL_WE_BIT];
                    prog_ee_d = sfr_wdata[`RFG_PROGRAM_STORE_CONTROL_EE_BIT];
                end
                default: begin
                end
            endcase
        end
        // reset state clears the select, smon and program store bits, not the pin flag or read data
        if (!rst_pin_n) begin
            clock_source_bit_d = 1'b0;
            smon_sel_d = 1'b0;
            prog_we_d = 1'b0;
            prog_ee_d = 1'b0;
        end
        rdata_d = sfr_rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                `RFG_ADDR_CLKSRC: rdata_d = {7'h00, clock_source_bit_q};
                `RFG_ADDR_RESET_SOURCE_REGISTER: rdata_d = {6'h00, supply_monitor_reset_select_q,
                    pin_reset_flag_q};
                `RFG_ADDR_PROGRAM_STORE_CONTROL: rdata_d = {6'h00, prog_ee_q, prog_we_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // new requests win over ack, service waits
        pend_d = (irq_pending_q & ~irq_ack) | irq_req;
        serv_d = '0;
        if (int_global_en && !flash_busy) begin
            serv_d = rfg_first(irq_pending_q & ~irq_ack);
        end
        if (!rst_pin_n) begin
            pend_d = '0;
            serv_d = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pending_q <= '0;
            irq_service_q <= '0;
        end else begin
            irq_pending_q <= pend_d;
            irq_service_q <= serv_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_source_bit_q <= `RFG_CLKSRC_SEL_RESET;
            supply_monitor_reset_select_q <= 1'b0;
            prog_we_q <= 1'b0;
            prog_ee_q <= 1'b0;
            sfr_rdata_q <= 8'h00;
            flash_write_permit_q <= 1'b0;
            flash_erase_permit_q <= 1'b0;
        end else begin
            clock_source_bit_q <= clock_source_bit_d;
            supply_monitor_reset_select_q <= smon_sel_d;
            prog_we_q <= prog_we_d;
            prog_ee_q <= prog_ee_d;
            sfr_rdata_q <= rdata_d;
            // write alone or write plus erase
            flash_write_permit_q <= prog_we_d && !prog_ee_d;
            flash_erase_permit_q <= prog_we_d && prog_ee_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // divider applies only to internal source
        div_d = clock_source_bit_q ? '0 : internal_divider_field;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_clock_div_q <= '0;
        end else begin
            system_clock_div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // select bit drives the source switch
    rfg_clk_switch #(
        .GAP_CYC(`RFG_GAP_CYC)
    ) rfg_clk_switch_i (
        .clk(clk),
        .rst(rst),
        .sys_rst(!rst_pin_n),
        .sel_ext(clock_source_bit_q),
        .int_en(int_osc_gate_q),
        .ext_en(ext_osc_gate_q)
    );

endmodule : rfg_top

// ==== verification/rfg_chk.sv ====
// assertions on the ports of rfg_top
// assumes one clock domain with rst async active high
`timescale 1ns/10ps

module rfg_chk
    import rfg_pkg::*;
#(
    parameter int IRQ_N = 8,
    parameter int DIV_W = 2
) (
    // clock, reset, pin
    input wire logic clk,
    input wire logic rst,
    input wire logic rst_pin_n,
    input wire logic sys_reset_q,
    // sfr bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_q,
    // flash and interrupts
    input wire logic flash_busy,
    input wire logic flash_write_permit_q,
    input wire logic flash_erase_permit_q,
    input wire logic [IRQ_N-1:0] irq_ack,
    input wire logic [IRQ_N-1:0] irq_pending_q,
    input wire logic [IRQ_N-1:0] irq_service_q,
    // clock source
    input wire logic [DIV_W-1:0] system_clock_div_q,
    input wire logic int_osc_gate_q,
    input wire logic ext_osc_gate_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_pin_holds: assert property (!rst_pin_n |=> sys_reset_q)
        else $error("pin low without reset");
    a_release_pin: assert property ($fell(sys_reset_q) |-> $past(rst_pin_n))
        else $error("reset left with pin low");
    a_gates_apart: assert property (!(int_osc_gate_q && ext_osc_gate_q))
        else $error("both clock gates open");
    // a gap stops a short pulse at the switch
    a_gap_held: assert property ($fell(int_osc_gate_q) |-> !ext_osc_gate_q[*2])
        else $error("clock gap too short");
    a_ext_div: assert property (ext_osc_gate_q |-> system_clock_div_q == '0)
        else $error("divider on external clock");
    a_permit_excl: assert property (!(flash_write_permit_q && flash_erase_permit_q))
        else $error("write and erase permit together");
    a_busy_quiet: assert property (flash_busy ##1 flash_busy |-> irq_service_q == '0)
        else $error("service during flash");
    a_pend_kept: assert property (rst_pin_n |=>
        &(irq_pending_q | ~$past(irq_pending_q) | $past(irq_ack)))
        else $error("pending bit lost");
    a_one_served: assert property ($onehot0(irq_service_q))
        else $error("service not one-hot");
    a_clk_rsvd: assert property (sfr_rd && sfr_addr == 8'ha9 |=> sfr_rdata_q[7:1] == 7'h00)
        else $error("reserved bits read nonzero");
endmodule : rfg_chk

bind rfg_top rfg_chk #(.IRQ_N(IRQ_N), .DIV_W(DIV_W)) rfg_chk_i (.clk, .rst, .rst_pin_n,
    .sys_reset_q, .sfr_addr, .sfr_rd, .sfr_rdata_q, .flash_busy, .flash_write_permit_q,
    .flash_erase_permit_q, .irq_ack, .irq_pending_q, .irq_service_q, .system_clock_div_q,
    .int_osc_gate_q, .ext_osc_gate_q);

// ==== verification/rfg_pin_model.sv ====
// external reset circuit on the reset pin
// assumes hold changes only at the falling clock edge
`timescale 1ns/10ps

module rfg_pin_model (
    // command and pin
    input wire logic hold,
    output logic rst_pin_n
);
    ////////////////////////////////////////
    // pulled up, low forces reset
    assign rst_pin_n = !hold;
endmodule : rfg_pin_model

// ==== verification/tb_rfg_top.sv ====
// self-checking bench for rfg_top
// assumes checker and pin model compile first
`timescale 1ns/10ps

module tb_rfg_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hold = 1'b0;
    logic rst_pin_n;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata_q;
    logic sys_reset_q, supply_monitor_reset_select_q;
    logic flash_busy = 1'b0;
    logic flash_write_permit_q, flash_erase_permit_q;
    logic int_global_en = 1'b0;
    logic [7:0] irq_req = 8'h00;
    logic [7:0] irq_ack = 8'h00;
    logic [7:0] irq_pending_q, irq_service_q;
    logic [1:0] internal_divider_field = 2'h2;
    logic [1:0] system_clock_div_q;
    logic int_osc_gate_q, ext_osc_gate_q;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    ////////////////////////////////////////
    rfg_pin_model rfg_pin_model_i (.hold, .rst_pin_n);
    rfg_top rfg_top_i (.clk, .rst, .rst_pin_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata_q, .sys_reset_q, .supply_monitor_reset_select_q, .flash_busy,
        .flash_write_permit_q, .flash_erase_permit_q, .int_global_en, .irq_req, .irq_ack,
        .irq_pending_q, .irq_service_q, .internal_divider_field, .system_clock_div_q,
        .int_osc_gate_q, .ext_osc_gate_q);
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            conclude();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        idle(1);
        chk(sfr_rdata_q, exp);
    endtask : rd
    task automatic conclude;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    task automatic t_reset;
        rd(8'ha9, 8'h00);
        rd(8'hef, 8'h00);
        rd(8'h10, 8'h00);
        chk({6'h00, ext_osc_gate_q, int_osc_gate_q}, 8'h01);
        $display("reset test done");
    endtask : t_reset
    task automatic t_pin;
        hold = 1'b1;
        wr(8'ha9, 8'h01);
        chk({7'h00, sys_reset_q}, 8'h01);
        hold = 1'b0;
        idle(3);
        chk({7'h00, sys_reset_q}, 8'h00);
        rd(8'hef, 8'h01);
        rd(8'ha9, 8'h00);
        wr(8'hef, 8'h02);
        rd(8'hef, 8'h03);
        chk({7'h00, supply_monitor_reset_select_q}, 8'h01);
        $display("pin test done");
    endtask : t_pin
    task automatic t_clk;
        wr(8'ha9, 8'h01);
        idle(1);
        chk({6'h00, ext_osc_gate_q, int_osc_gate_q}, 8'h00);
        idle(2);
        chk({6'h00, ext_osc_gate_q, int_osc_gate_q}, 8'h02);
        chk({6'h00, system_clock_div_q}, 8'h00);
        wr(8'ha9, 8'h01);
        rd(8'ha9, 8'h01);
        wr(8'ha9, 8'h00);
        idle(4);
        chk({6'h00, ext_osc_gate_q, int_osc_gate_q}, 8'h01);
        chk({6'h00, system_clock_div_q}, 8'h02);
        $display("clock test done");
    endtask : t_clk
    task automatic t_flash;
        wr(8'h8f, 8'h01);
        chk({6'h00, flash_erase_permit_q, flash_write_permit_q}, 8'h01);
        wr(8'h8f, 8'h03);
        chk({6'h00, flash_erase_permit_q, flash_write_permit_q}, 8'h02);
        wr(8'h8f, 8'h00);
        chk({6'h00, flash_erase_permit_q, flash_write_permit_q}, 8'h00);
        $display("flash test done");
    endtask : t_flash
    task automatic t_irq;
        flash_busy = 1'b1;
        idle(1);
        irq_req = 8'h0a;
        idle(1);
        irq_req = 8'h00;
        idle(2);
        chk(irq_pending_q, 8'h0a);
        chk(irq_service_q, 8'h00);
        flash_busy = 1'b0;
        int_global_en = 1'b1;
        idle(3);
        chk(irq_service_q, 8'h02);
        irq_ack = 8'h02;
        idle(1);
        irq_ack = 8'h00;
        idle(3);
        chk(irq_pending_q, 8'h08);
        chk(irq_service_q, 8'h08);
        $display("interrupt test done");
    endtask : t_irq
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_pin();
        t_clk();
        t_flash();
        t_irq();
        conclude();
    end
endmodule : tb_rfg_top
